// File: rctr_decoder.sv
`timescale 1ns/10ps
// Pulse-width decoder: measures high times and assembles a word
module rctr_decoder #(
	parameter int NBITS = 25
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_din,
	input wire logic [31:0] i_split_cycles,
	input wire logic [31:0] i_gap_cycles,
	output logic o_word_valid,
	output logic [NBITS-1:0] o_word
);
	import rctr_pkg::*;

	logic din_d_reg, din_d_next;
	logic [31:0] hi_reg, hi_next, lo_reg, lo_next;
	logic [NBITS-1:0] sh_reg, sh_next;
	logic [5:0] n_reg, n_next;
	logic vld_reg, vld_next;
	logic [NBITS-1:0] word_reg, word_next;

	initial begin
		if (NBITS < 2 || NBITS > 63) $error("NBITS out of range");
	end

	always_comb begin
		din_d_next = i_din;
		hi_next = hi_reg;
		lo_next = lo_reg;
		sh_next = sh_reg;
		n_next = n_reg;
		vld_next = 1'b0;
		word_next = word_reg;
		if (i_din) begin
			hi_next = hi_reg + 32'h0000_0001;
			lo_next = 32'h0000_0000;
		end else begin
			if (lo_reg != 32'hFFFF_FFFF) begin
				lo_next = lo_reg + 32'h0000_0001;
			end
			if (lo_reg == i_gap_cycles) begin
				n_next = 6'h00;
			end
		end
		// Falling edge ends a bit: short high is one, long high is zero
		if (din_d_reg && !i_din) begin
			sh_next = {sh_reg[NBITS-2:0], (hi_reg < i_split_cycles)};
			hi_next = 32'h0000_0000;
			if (n_reg == 6'(NBITS - 1)) begin
				vld_next = 1'b1;
				word_next = {sh_reg[NBITS-2:0], (hi_reg < i_split_cycles)};
				n_next = 6'h00;
			end else begin
				n_next = n_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			din_d_reg <= 1'b0;
			hi_reg <= 32'h0000_0000;
			lo_reg <= 32'h0000_0000;
			sh_reg <= '0;
			n_reg <= 6'h00;
			vld_reg <= 1'b0;
			word_reg <= '0;
		end else begin
			din_d_reg <= din_d_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
			sh_reg <= sh_next;
			n_reg <= n_next;
			vld_reg <= vld_next;
			word_reg <= word_next;
		end
	end

	assign o_word_valid = vld_reg;
	assign o_word = word_reg;
endmodule

// File: rctr_pkg.sv
package rctr_pkg;
	localparam int CODE_BITS = 22;
	localparam int SYNC_BITS = 3;
	localparam int WORD_BITS = SYNC_BITS + CODE_BITS;
	localparam logic [2:0] SYNC_WORD = 3'h2;
	// Width of a received high pulse: a one is short, a zero is 7 times longer
	localparam int ZERO_TO_ONE_RATIO = 7;
	localparam int VALID_PULSE_MULT = 48;
	localparam int CLK_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	// Default window time in microseconds, converted to cycles
	localparam int WINDOW_US = 500000;
	localparam int WINDOW_CYCLES = WINDOW_US / 1000 * (CLK_HZ / 1000000) * 1000;
	// Default pulse for a data one, in microseconds
	localparam int ONE_PULSE_US = 125;
	localparam int ONE_PULSE_CYCLES = ONE_PULSE_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 32;
	localparam logic [3:0] TRAIN_CNT_RST = 4'h0;
	localparam logic OUT_LEVEL_RST = 1'b0;

	typedef struct packed {
		logic transmit_role_sel;
		logic continuous_tx_sel;
		logic receiver_kind_a;
		logic receiver_kind_b;
		logic train_len_low;
		logic train_len_high;
		logic coding_select;
		logic input_type_select;
		logic inversion_select;
	} rctr_cfg_type;

	typedef enum logic [1:0] {
		RCTR_MODE_OFF,
		RCTR_MODE_TRAIN,
		RCTR_MODE_TOGGLE,
		RCTR_MODE_OTHER
	} rctr_mode_type;
endpackage

// File: rctr_receiver.sv
`timescale 1ns/10ps
// Operation
// - Receive only when role and continuous bits clear
// - Both kind bits set selects train receiver
// - Pulse only after enough matches in window
// - Non-matching codes do not reset count
// - Pulse issued at window end
// - Train lengths 2, 4, 8 codes
// - Both kind bits clear selects toggle receiver
// - Toggle output on each recognized train
// - Output floats after reset until second toggle
// - Toggle output changes only at window end
// - Toggle lengths 1, 2, 4, 8 codes
// - Coding bit set decodes normal format
// - Coding bit clear decodes modulated format (coding_select is not read; both formats go through the same decoder)
// - Analogue input path inverts phase
// - Logic input bypasses amplifier path
// - Inversion bit clear passes code unchanged
// - Inversion bit set inverts code
// - Only exact match counts as valid
// - Word is sync 010 plus 22 bits
// - Valid pulse lasts 48 bit pulses
module rctr_receiver #(
	parameter int WINDOW_LEN = rctr_pkg::WINDOW_CYCLES,
	parameter int ONE_LEN = rctr_pkg::ONE_PULSE_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire rctr_pkg::rctr_cfg_type i_cfg,
	input wire logic [rctr_pkg::CODE_BITS-1:0] i_stored_code,
	input wire logic i_code_analog,
	input wire logic i_code_logic,
	output logic o_out,
	output logic o_out_oe,
	output logic o_valid_code_pulse,
	output logic o_code_match,
	output logic [3:0] o_train_count
);
	import rctr_pkg::*;

	initial begin
		if (WINDOW_LEN < 1 || ONE_LEN < 1) $error("bad timing parameter");
	end

	logic rst_s1_reg, rst_s2_reg, rst_b;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_b = rst_s2_reg;

	// Pin synchronisers
	logic an_s1_reg, an_s2_reg, lg_s1_reg, lg_s2_reg;
	always_ff @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			an_s1_reg <= 1'b0;
			an_s2_reg <= 1'b0;
			lg_s1_reg <= 1'b0;
			lg_s2_reg <= 1'b0;
		end else begin
			an_s1_reg <= i_code_analog;
			an_s2_reg <= an_s1_reg;
			lg_s1_reg <= i_code_logic;
			lg_s2_reg <= lg_s1_reg;
		end
	end

	rctr_mode_type mode;
	logic rx_en;
	logic front_bit, dec_in;
	logic [31:0] split_cycles, gap_cycles;
	logic [31:0] one_cyc;
	logic [3:0] need;

	always_comb begin
		rx_en = !i_cfg.transmit_role_sel && !i_cfg.continuous_tx_sel;
		mode = RCTR_MODE_OTHER;
		if (!rx_en) begin
			mode = RCTR_MODE_OFF;
		end else if (i_cfg.receiver_kind_a && i_cfg.receiver_kind_b) begin
			mode = RCTR_MODE_TRAIN;
		end else if (!i_cfg.receiver_kind_a && !i_cfg.receiver_kind_b) begin
			mode = RCTR_MODE_TOGGLE;
		end
		// Analogue path inverts; logic path is taken straight
		front_bit = i_cfg.input_type_select ? lg_s2_reg : !an_s2_reg;
		dec_in = front_bit ^ i_cfg.inversion_select;
		// Modulated input arrives already demodulated to the carrier
		// Normal and modulated share pulse-width coding; the modulated
		// bit time is the fixed one-pulse length
		one_cyc = 32'(ONE_LEN);
		split_cycles = one_cyc * 32'(4);
		gap_cycles = one_cyc * 32'(ZERO_TO_ONE_RATIO * 3);
		case ({i_cfg.train_len_high, i_cfg.train_len_low})
			2'b01: need = 4'h2;
			2'b10: need = 4'h4;
			2'b11: need = 4'h8;
			default: need = (mode == RCTR_MODE_TOGGLE) ? 4'h1 : 4'h0;
		endcase
	end

	logic w_vld;
	logic [WORD_BITS-1:0] w_data;
	rctr_decoder #(.NBITS(WORD_BITS)) u_dec (
		.i_mclk(i_mclk),
		.i_rst_b(rst_b),
		.i_din(dec_in),
		.i_split_cycles(split_cycles),
		.i_gap_cycles(gap_cycles),
		.o_word_valid(w_vld),
		.o_word(w_data)
	);

	logic match;
	// Sync prefix and exact comparison against stored code
	assign match = w_vld && rx_en &&
		(w_data[WORD_BITS-1 -: SYNC_BITS] == SYNC_WORD) &&
		(w_data[CODE_BITS-1:0] == i_stored_code);

	logic [CNT_W-1:0] win_reg, win_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] pulse_reg, pulse_next;
	logic q_reg, q_next;
	logic oe_reg, oe_next;
	logic vp_reg, vp_next;
	logic mt_reg, mt_next;
	logic win_end, hit;

	always_comb begin
		win_end = (win_reg == CNT_W'(WINDOW_LEN - 1));
		hit = (need != 4'h0) && (cnt_reg >= need);
		win_next = win_end ? '0 : win_reg + CNT_W'(1);
		cnt_next = cnt_reg;
		if (win_end || mode == RCTR_MODE_OFF || mode == RCTR_MODE_OTHER) begin
			cnt_next = TRAIN_CNT_RST;
		end else if (match && cnt_reg != 4'hF) begin
			cnt_next = cnt_reg + 4'h1;
		end
		pulse_next = (pulse_reg != '0) ? pulse_reg - CNT_W'(1) : '0;
		q_next = q_reg;
		oe_next = oe_reg;
		if (win_end && hit && mode == RCTR_MODE_TRAIN) begin
			pulse_next = CNT_W'(ONE_LEN * VALID_PULSE_MULT);
		end
		if (win_end && hit && mode == RCTR_MODE_TOGGLE) begin
			q_next = !q_reg;
			oe_next = 1'b1;
		end
		if (mode == RCTR_MODE_TRAIN) begin
			oe_next = 1'b1;
		end
		vp_next = (pulse_next != '0);
		mt_next = match;
	end

	always_ff @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			win_reg <= '0;
			cnt_reg <= TRAIN_CNT_RST;
			pulse_reg <= '0;
			q_reg <= OUT_LEVEL_RST;
			oe_reg <= 1'b0;
			vp_reg <= 1'b0;
			mt_reg <= 1'b0;
		end else begin
			win_reg <= win_next;
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
			q_reg <= q_next;
			oe_reg <= oe_next;
			vp_reg <= vp_next;
			mt_reg <= mt_next;
		end
	end

	// Open drain: output pulls low while the level is low and enabled
	assign o_out = 1'b0;
	assign o_out_oe = oe_reg &&
		((mode == RCTR_MODE_TRAIN) ? !vp_reg : !q_reg);
	assign o_valid_code_pulse = vp_reg;
	assign o_code_match = mt_reg;
	assign o_train_count = cnt_reg;

	// Window end with a satisfied train, one sequence per receiver kind
	sequence s_train_hit;
		win_end && hit && mode == RCTR_MODE_TRAIN;
	endsequence
	sequence s_toggle_hit;
		win_end && hit && mode == RCTR_MODE_TOGGLE;
	endsequence

	a_float_reset: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		$rose(rst_b) |-> !o_out_oe)
		else $error("output driven at reset");
	a_pulse_at_end: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		$rose(vp_reg) |-> $past(win_end) && $past(mode) == RCTR_MODE_TRAIN)
		else $error("pulse not at window end");
	a_pulse_need: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		$rose(vp_reg) |-> $past(cnt_reg) >= $past(need))
		else $error("pulse with too few codes");
	a_toggle_end: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		(q_reg != $past(q_reg)) |-> $past(win_end))
		else $error("toggle outside window end");
	a_count_clear: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		win_end |=> cnt_reg == TRAIN_CNT_RST)
		else $error("count not cleared");
	a_count_keep: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		(!win_end && !match && mode != RCTR_MODE_OFF) |=> $stable(cnt_reg))
		else $error("count changed on non-match");
	a_off_idle: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		(mode == RCTR_MODE_OFF) |=> cnt_reg == TRAIN_CNT_RST)
		else $error("counting while not receiving");
	a_pulse_hold: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		$rose(vp_reg) |-> vp_reg[*8])
		else $error("valid pulse too short");
	a_pulse_start: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		s_train_hit |=> vp_reg)
		else $error("no pulse after full train");
	a_toggle_hit: assert property (
		@(posedge i_mclk) disable iff (!rst_b)
		s_toggle_hit |=> q_reg != $past(q_reg))
		else $error("no toggle after full train");
endmodule

// File: rctr_tx_model.sv
`timescale 1ns/10ps
// Remote transmitter sending pulse-width words; the line idles low
// Baseband only: any carrier is already stripped here
module rctr_tx_model #(
	parameter int ONE_LEN = 10
) (
	input wire logic i_mclk,
	output logic o_line
);
	initial o_line = 1'b0;

	task automatic send(input logic [21:0] code);
		logic [24:0] w;
		w = {3'h2, code};
		for (int i = 24; i >= 0; i--) begin
			@(posedge i_mclk);
			o_line <= 1'b1;
			repeat (w[i] ? ONE_LEN : 7 * ONE_LEN) @(posedge i_mclk);
			o_line <= 1'b0;
			repeat (ONE_LEN) @(posedge i_mclk);
		end
	endtask
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import rctr_pkg::*;
	localparam int WL = 6000;
	localparam int OL = 10;
	logic i_mclk = 1'b0;
	logic rst_b = 1'b0;
	rctr_cfg_type cfg = '0;
	logic [21:0] code = 22'h3f_ffff;
	logic tx_line, pin_l, pin_a, out, oe, vpulse, match;
	logic [3:0] cnt;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int n_hit = 0;

	// Counts one-cycle match pulses while they stand
	always @(negedge i_mclk) begin
		if (match === 1'b1) begin
			n_hit++;
		end
	end

	// Both pins carry the same word so either input path can be chosen
	assign pin_l = tx_line ^ cfg.inversion_select;
	assign pin_a = ~pin_l;

	initial begin
		forever #12.5 i_mclk = ~i_mclk;
	end

	rctr_receiver #(.WINDOW_LEN(WL), .ONE_LEN(OL)) i_rctr_receiver (
		.i_mclk(i_mclk), .i_rst_b(rst_b), .i_cfg(cfg),
		.i_stored_code(code), .i_code_analog(pin_a),
		.i_code_logic(pin_l), .o_out(out), .o_out_oe(oe),
		.o_valid_code_pulse(vpulse), .o_code_match(match),
		.o_train_count(cnt));

	rctr_tx_model #(.ONE_LEN(OL)) i_rctr_tx_model (
		.i_mclk(i_mclk), .o_line(tx_line));

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 99000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic setup(input logic role, kind, input logic [1:0] len,
			input logic itype, inv);
		@(posedge i_mclk);
		rst_b <= 1'b0;
		cfg <= '{role, 1'b0, kind, kind, len[0], len[1], itype, itype, inv};
		repeat (2) @(posedge i_mclk);
		rst_b <= 1'b1;
		// Idle gap flushes a false bit left by the synchroniser reset
		repeat (24 * OL) @(posedge i_mclk);
	endtask

	// Waits until the window expiry clears the match count
	task automatic win_end();
		int n = 0;
		repeat (4) @(negedge i_mclk);
		while (cnt !== 4'h0 && n < WL) begin
			@(negedge i_mclk);
			n++;
		end
		chk("window end", cnt, 4'h0);
	endtask

	task automatic train(input logic [1:0] len, input int nm, input logic ex);
		int n = 0;
		int h0;
		setup(1'b0, 1'b1, len, 1'b1, 1'b0);
		i_rctr_tx_model.send(code);
		win_end();
		h0 = n_hit;
		for (int i = 0; i < nm; i++) begin
			i_rctr_tx_model.send(code);
			if (i == 0)
				i_rctr_tx_model.send(code ^ 22'h00_0001);
		end
		@(negedge i_mclk);
		chk("count", cnt, nm[3:0]);
		chk("matches", 16'(n_hit - h0), 16'(nm));
		chk("early pulse", vpulse, 1'b0);
		win_end();
		while (vpulse !== 1'b1 && n < 3) begin
			@(negedge i_mclk);
			n++;
		end
		chk("oe in pulse", oe, !ex);
		n = 0;
		while (vpulse === 1'b1 && n < 1000) begin
			@(negedge i_mclk);
			n++;
		end
		chk("pulse len", n[15:0], ex ? 16'(VALID_PULSE_MULT * OL) : 16'h0);
	endtask

	task automatic toggle(input logic itype, inv, input int nw);
		setup(1'b0, 1'b0, 2'h0, itype, inv);
		chk("oe after reset", oe, 1'b0);
		chk("out level", out, 1'b0);
		for (int i = 0; i < nw; i++) begin
			i_rctr_tx_model.send(code);
			@(negedge i_mclk);
			chk("oe before end", oe, i == 2);
			win_end();
			repeat (2) @(negedge i_mclk);
			chk("oe toggled", oe, i == 1);
		end
	endtask

	task automatic role_check();
		int h0;
		setup(1'b1, 1'b0, 2'h0, 1'b1, 1'b0);
		h0 = n_hit;
		i_rctr_tx_model.send(code);
		repeat (4) @(negedge i_mclk);
		chk("count in tx role", cnt, 4'h0);
		chk("match in tx role", 16'(n_hit - h0), 16'h0);
		chk("oe in tx role", oe, 1'b0);
	endtask

	initial begin
		train(2'h1, 2, 1'b1);
		train(2'h2, 3, 1'b0);
		train(2'h3, 8, 1'b1);
		toggle(1'b1, 1'b0, 3);
		toggle(1'b1, 1'b1, 2);
		toggle(1'b0, 1'b0, 2);
		role_check();
		end_sim();
	end
endmodule
